// *** rtl/fsp_dev.sv ***
// Device end: sector protection command interpreter of the serial flash
`timescale 1ns/100ps
module fsp_dev
	import fsp_pkg::*;
#(
	parameter int NUM_SECT  = FSP_NUM_SECT,
	parameter int PROG_CYC  = FSP_PROG_CYC,
	parameter int ERASE_CYC = FSP_ERASE_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Serial link
	fsp_link_if.dev         link,
	// Configuration
	input  wire logic [7:0] bank_addr,
	input  wire logic       quad_command_mode,
	// Status
	output logic            busy_flag,
	output logic            write_enable_latch,
	output logic            nv_protect_lock_bit
);

	localparam int SW = $clog2(NUM_SECT);

	if (NUM_SECT < 2 || (1 << SW) != NUM_SECT || SW + FSP_SECT_LSB > 32)
		$error("NUM_SECT must be a power of two fitting the address");
	if (PROG_CYC < 1 || ERASE_CYC < 1 ||
	    ERASE_CYC >= (1 << FSP_TIMER_W) || PROG_CYC >= (1 << FSP_TIMER_W))
		$error("operation times out of timer range");

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: sck, cs_n, mosi

	logic [2:0] pin_raw;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic       sck_d_q;
	logic       cs_d_q;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;

	assign pin_raw = {link.sck, link.cs_n, link.mosi};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge sys_clk or negedge arst_n) begin
			if (!arst_n) begin
				s1_q[i] <= (i == 1);
				s2_q[i] <= (i == 1);
			end else begin
				s1_q[i] <= pin_raw[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_d_q <= 1'b0;
			cs_d_q  <= 1'b1;
		end else begin
			sck_d_q <= s2_q[2];
			cs_d_q  <= s2_q[1];
		end
	end

	assign sck_rise = s2_q[2] & ~sck_d_q & ~s2_q[1];
	assign sck_fall = ~s2_q[2] & sck_d_q & ~s2_q[1];
	assign cs_rise  = s2_q[1] & ~cs_d_q;

	////////////////////////////////////////////////////////////////////////
	// Input shifter and bit counter

	logic [31:0]          sr_q;
	logic [FSP_CNT_W-1:0] cnt_q;
	logic [7:0]           op_q;
	logic [7:0]           cur_op;
	logic [FSP_CNT_W-1:0] hdr;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sr_q  <= '0;
			cnt_q <= '0;
		end else if (s2_q[1]) begin
			cnt_q <= '0;
		end else if (sck_rise) begin
			sr_q <= {sr_q[30:0], s2_q[0]};
			if (cnt_q != FSP_CNT_MAX)
				cnt_q <= cnt_q + 7'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			op_q <= 8'h00;
		else if (cnt_q == FSP_OP_BITS)
			op_q <= sr_q[7:0];
	end

	assign cur_op = (cnt_q == FSP_OP_BITS) ? sr_q[7:0] : op_q;

	// Opcode bits plus address bits for each command
	function automatic logic [6:0] hdr_bits(input logic [7:0] op,
	                                        input logic       ext);
		case (op)
			FSP_OP_RD_VOL, FSP_OP_WR_VOL, FSP_OP_RD_NV, FSP_OP_PG_NV:
				hdr_bits = FSP_OP_BITS + (ext ? FSP_A4_BITS : FSP_A3_BITS);
			FSP_OP_RD_VOL_W, FSP_OP_WR_VOL_W, FSP_OP_RD_NV_W, FSP_OP_PG_NV_W:
				hdr_bits = FSP_OP_BITS + FSP_A4_BITS;
			default:
				hdr_bits = FSP_OP_BITS;
		endcase
	endfunction

	assign hdr = hdr_bits(cur_op, bank_addr[FSP_EXT_BIT]);

	////////////////////////////////////////////////////////////////////////
	// Protection state

	logic [7:0]        vol_q [NUM_SECT];
	logic [7:0]        nv_q  [NUM_SECT];
	logic [15:0]       mode_q;
	logic [31:0]       addr_w;
	logic [SW-1:0]     sect_w;
	logic [SW-1:0]     sect_q;
	logic [SW-1:0]     hsect_q;
	fsp_dev_st_t       st_q;
	fsp_op_t           kind_q;
	logic [FSP_TIMER_W-1:0] tim_q;
	logic [15:0]       data_q;
	logic              done;

	// Short address takes its upper bits from the bank register
	assign addr_w = (hdr == FSP_OP_BITS + FSP_A4_BITS) ? sr_q :
	                {1'b0, bank_addr[6:0], sr_q[23:0]};
	assign sect_w = addr_w[FSP_SECT_LSB +: SW];
	assign done   = (st_q == DS_BUSY) && (tim_q == '0);

	// A write's data byte pushes the address out of the shifter, so the
	// sector is caught as soon as the header is complete
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			hsect_q <= '0;
		else if (!s2_q[1] && cnt_q == hdr)
			hsect_q <= sect_w;
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: load a 16-bit pattern, shift it out on sck falls

	logic [15:0] out_q;
	logic [3:0]  idx_q;
	logic        out_en_q;
	logic        so_q;
	logic        rd_ok;
	logic [15:0] rd_word;

	always_comb begin
		rd_ok   = (st_q == DS_IDLE);
		rd_word = '0;
		case (cur_op)
			FSP_OP_READ_STATUS: begin
				rd_ok   = 1'b1;
				rd_word = {2{6'h00, write_enable_latch, busy_flag}};
			end
			FSP_OP_RD_VOL, FSP_OP_RD_VOL_W:
				rd_word = {2{vol_q[sect_w]}};
			FSP_OP_RD_NV, FSP_OP_RD_NV_W: begin
				rd_ok   = rd_ok & ~quad_command_mode;
				rd_word = {2{nv_q[sect_w]}};
			end
			FSP_OP_RD_MODE:
				rd_word = {mode_q[7:0], mode_q[15:8]};
			FSP_OP_RD_LOCK: begin
				rd_ok   = rd_ok & ~quad_command_mode;
				rd_word = {2{7'h00, nv_protect_lock_bit}};
			end
			default:
				rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q    <= '0;
			out_en_q <= 1'b0;
		end else if (s2_q[1]) begin
			out_en_q <= 1'b0;
		end else if (!out_en_q && cnt_q == hdr && rd_ok) begin
			out_q    <= rd_word;
			out_en_q <= 1'b1;
		end
	end

	// Index wraps at 16 so the same pattern repeats
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_q <= 4'h0;
			so_q  <= 1'b0;
		end else if (s2_q[1]) begin
			idx_q <= 4'h0;
			so_q  <= 1'b0;
		end else if (out_en_q && sck_fall) begin
			so_q  <= out_q[~idx_q];
			idx_q <= idx_q + 4'h1;
		end
	end

	assign link.miso = so_q;

	////////////////////////////////////////////////////////////////////////
	// Frame end: decide what a deselect starts

	fsp_op_t   go_kind;
	logic [6:0] full_hdr;

	assign full_hdr = hdr_bits(op_q, bank_addr[FSP_EXT_BIT]);

	always_comb begin
		go_kind = OP_NONE;
		if (cs_rise && st_q == DS_IDLE && write_enable_latch) begin
			case (op_q)
				FSP_OP_WR_VOL, FSP_OP_WR_VOL_W:
					if (cnt_q == full_hdr + FSP_B_BITS)
						go_kind = OP_VOLW;
				FSP_OP_PG_NV, FSP_OP_PG_NV_W:
					if (cnt_q == full_hdr)
						go_kind = OP_NVPG;
				FSP_OP_ER_NV:
					if (cnt_q == FSP_OP_BITS)
						go_kind = OP_NVER;
				FSP_OP_PG_MODE:
					if (cnt_q == FSP_OP_BITS + FSP_B_BITS + FSP_B_BITS)
						go_kind = OP_MODEPG;
				FSP_OP_CLR_LOCK:
					if (cnt_q == FSP_OP_BITS)
						go_kind = OP_LOCKCLR;
				// Suspend has no effect here, so erase runs to the end
				FSP_OP_ERASE_SUSP:
					go_kind = OP_NONE;
				default:
					go_kind = OP_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Busy engine

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q   <= DS_IDLE;
			kind_q <= OP_NONE;
			tim_q  <= '0;
			sect_q <= '0;
			data_q <= '0;
		end else begin
			case (st_q)
				DS_IDLE:
					if (go_kind != OP_NONE) begin
						st_q   <= DS_BUSY;
						kind_q <= go_kind;
						sect_q <= hsect_q;
						// Mode bytes arrive low byte first
						data_q <= {sr_q[7:0], sr_q[15:8]};
						tim_q  <= (go_kind == OP_NVER) ?
						          FSP_TIMER_W'(ERASE_CYC - 1) :
						          FSP_TIMER_W'(PROG_CYC - 1);
					end
				DS_BUSY:
					if (done)
						st_q <= DS_IDLE;
					else
						tim_q <= tim_q - 1'b1;
				default:
					st_q <= DS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			busy_flag <= 1'b0;
		else
			busy_flag <= (st_q == DS_BUSY) && !done;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			write_enable_latch <= 1'b0;
		else if (done && kind_q != OP_VOLW)
			write_enable_latch <= 1'b0;
		else if (cs_rise && st_q == DS_IDLE && op_q == FSP_OP_WRITE_ENABLE &&
		         cnt_q == FSP_OP_BITS)
			write_enable_latch <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Protection arrays, mode register and lock bit update on completion

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int s = 0; s < NUM_SECT; s++)
				vol_q[s] <= FSP_VOL_RST;
		end else if (done && kind_q == OP_VOLW) begin
			vol_q[sect_q] <= data_q[15:8];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int s = 0; s < NUM_SECT; s++)
				nv_q[s] <= FSP_NV_RST;
		end else if (done && kind_q == OP_NVPG) begin
			nv_q[sect_q] <= FSP_NV_PROG;
		end else if (done && kind_q == OP_NVER) begin
			for (int s = 0; s < NUM_SECT; s++)
				nv_q[s] <= FSP_NV_ERASE;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			mode_q <= FSP_MODE_RST;
		else if (done && kind_q == OP_MODEPG)
			mode_q <= data_q;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			nv_protect_lock_bit <= 1'b1;
		else if (done && kind_q == OP_LOCKCLR)
			nv_protect_lock_bit <= 1'b0;
	end

endmodule // fsp_dev

// *** rtl/fsp_host.sv ***
// Host end: Wishbone-programmed serial controller for protection commands
`timescale 1ns/100ps
module fsp_host
	import fsp_pkg::*;
#(
	parameter int SCK_HALF = FSP_SCK_HALF
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Wishbone slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	// Serial link
	fsp_link_if.host         link
);

	if (SCK_HALF < 4 || SCK_HALF > 255)
		$error("SCK_HALF must be 4..255 to leave room for sync delay");

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [17:0]  ctrl_q;
	logic [31:0]  addr_q;
	logic [15:0]  wdata_q;
	logic [15:0]  rdata_q;
	logic         done_q;
	logic         wr_acc;
	logic         go;
	logic [31:0]  mask;
	fsp_host_st_t st_q;

	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign mask[8*b +: 8] = {8{wb_sel[b]}};
	end

	// Write takes effect at the edge that samples ack high
	assign wr_acc = wb_cyc & wb_stb & wb_we & wb_ack;
	assign go = wr_acc && wb_adr == FSP_REG_CTRL && wb_sel[3] &&
	            wb_dat_w[FSP_CTRL_GO] && st_q == HS_IDLE;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q  <= '0;
			addr_q  <= '0;
			wdata_q <= '0;
		end else if (wr_acc && st_q == HS_IDLE) begin
			case (wb_adr)
				FSP_REG_CTRL:
					ctrl_q <= (ctrl_q & ~mask[17:0]) | (wb_dat_w[17:0] & mask[17:0]);
				FSP_REG_ADDR:
					addr_q <= (addr_q & ~mask) | (wb_dat_w & mask);
				FSP_REG_WDATA:
					wdata_q <= (wdata_q & ~mask[15:0]) | (wb_dat_w[15:0] & mask[15:0]);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack   <= 1'b0;
			wb_dat_r <= '0;
		end else begin
			wb_ack <= wb_cyc & wb_stb & ~wb_ack;
			case (wb_adr)
				FSP_REG_CTRL:
					wb_dat_r <= {st_q != HS_IDLE, done_q, 12'h000, ctrl_q};
				FSP_REG_ADDR:
					wb_dat_r <= addr_q;
				FSP_REG_WDATA:
					wb_dat_r <= {16'h0000, wdata_q};
				FSP_REG_RDATA:
					wb_dat_r <= {16'h0000, rdata_q};
				default:
					wb_dat_r <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame engine

	logic [1:0]  miso_s_q;
	logic [55:0] tx_q;
	logic [15:0] rx_q;
	logic [6:0]  bit_q;
	logic [6:0]  total;
	logic [7:0]  tim_q;
	logic [47:0] body;
	logic [2:0]  ab;
	logic [2:0]  ab_req;
	logic [1:0]  rb;

	// The GO write loads tx at the same edge that updates ctrl_q
	assign ab_req = go ? wb_dat_w[FSP_CTRL_AB_LSB +: 3] :
	                ctrl_q[FSP_CTRL_AB_LSB +: 3];
	assign ab    = (ab_req > 3'h4) ? 3'h4 : ab_req;
	assign rb    = ctrl_q[FSP_CTRL_RB_LSB +: 2];
	// Unused high address bytes fall off the top of the shift
	assign body  = {addr_q, wdata_q[7:0], wdata_q[15:8]} << (6'(4 - ab) * 6'h08);
	assign total = {4'h1 + {1'b0, ab} + {2'b00, ctrl_q[FSP_CTRL_WB_LSB +: 2]} +
	               {2'b00, rb}, 3'h0};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			miso_s_q <= 2'h0;
		else
			miso_s_q <= {miso_s_q[0], link.miso};
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q      <= HS_IDLE;
			link.cs_n <= 1'b1;
			link.sck  <= 1'b0;
			link.mosi <= 1'b0;
			tx_q      <= '0;
			rx_q      <= '0;
			bit_q     <= '0;
			tim_q     <= '0;
		end else begin
			if (st_q != HS_IDLE && tim_q != 8'h00)
				tim_q <= tim_q - 8'h01;
			case (st_q)
				HS_IDLE:
					if (go) begin
						link.cs_n <= 1'b0;
						link.mosi <= wb_dat_w[FSP_CTRL_OP_LSB + 7];
						tx_q <= {wb_dat_w[FSP_CTRL_OP_LSB +: 8], body};
						bit_q <= '0;
						tim_q <= 8'(SCK_HALF - 1);
						st_q  <= HS_LOW;
					end
				HS_LOW:
					if (tim_q == 8'h00) begin
						link.sck <= 1'b1;
						tim_q <= 8'(SCK_HALF - 1);
						st_q  <= HS_HIGH;
					end
				HS_HIGH:
					if (tim_q == 8'h00) begin
						link.sck <= 1'b0;
						// Sampling at the end of the high phase leaves room
						// for both sync chains and the device's output delay
						rx_q  <= {rx_q[14:0], miso_s_q[1]};
						tim_q <= 8'(SCK_HALF - 1);
						bit_q <= bit_q + 7'h01;
						tx_q  <= {tx_q[54:0], 1'b0};
						link.mosi <= tx_q[54];
						st_q  <= (bit_q + 7'h01 == total) ? HS_TAIL : HS_LOW;
					end
				HS_TAIL:
					if (tim_q == 8'h00) begin
						link.cs_n <= 1'b1;
						link.mosi <= 1'b0;
						tim_q <= 8'(SCK_HALF - 1);
						st_q  <= HS_GAP;
					end
				HS_GAP:
					if (tim_q == 8'h00)
						st_q <= HS_IDLE;
				default:
					st_q <= HS_IDLE;
			endcase
		end
	end

	// First received byte lands in the low byte, for one or two read bytes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
			done_q  <= 1'b0;
		end else if (go) begin
			done_q <= 1'b0;
		end else if (st_q == HS_GAP && tim_q == 8'h00) begin
			done_q  <= 1'b1;
			rdata_q <= (rb == 2'h2) ? {rx_q[7:0], rx_q[15:8]} :
			           {8'h00, rx_q[7:0]};
		end
	end

endmodule // fsp_host

// *** rtl/fsp_link_if.sv ***
// Serial link between the flash controller and the protection logic
`timescale 1ns/100ps
interface fsp_link_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;

	modport dev (input cs_n, input sck, input mosi, output miso);
	modport host (output cs_n, output sck, output mosi, input miso);
endinterface

// *** rtl/fsp_pkg.sv ***
// Constants and types shared by both ends of the protection command link
package fsp_pkg;

	// Command opcodes
	localparam logic [7:0] FSP_OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] FSP_OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] FSP_OP_RD_VOL       = 8'hfa;
	localparam logic [7:0] FSP_OP_RD_VOL_W     = 8'he0;
	localparam logic [7:0] FSP_OP_WR_VOL       = 8'hfb;
	localparam logic [7:0] FSP_OP_WR_VOL_W     = 8'he1;
	localparam logic [7:0] FSP_OP_RD_NV        = 8'hfc;
	localparam logic [7:0] FSP_OP_RD_NV_W      = 8'he2;
	localparam logic [7:0] FSP_OP_PG_NV        = 8'hfd;
	localparam logic [7:0] FSP_OP_PG_NV_W      = 8'he3;
	localparam logic [7:0] FSP_OP_ER_NV        = 8'he4;
	localparam logic [7:0] FSP_OP_RD_MODE      = 8'h2b;
	localparam logic [7:0] FSP_OP_PG_MODE      = 8'h2f;
	localparam logic [7:0] FSP_OP_RD_LOCK      = 8'ha7;
	localparam logic [7:0] FSP_OP_CLR_LOCK     = 8'ha6;
	localparam logic [7:0] FSP_OP_ERASE_SUSP   = 8'h75;

	// Status byte and bank register fields
	localparam int FSP_ST_BUSY = 0;
	localparam int FSP_ST_WEL  = 1;
	localparam int FSP_EXT_BIT = 7;

	// Frame bit counts
	localparam int         FSP_CNT_W   = 7;
	localparam logic [6:0] FSP_CNT_MAX = 7'h7f;
	localparam logic [6:0] FSP_OP_BITS = 7'h08;
	localparam logic [6:0] FSP_A3_BITS = 7'h18;
	localparam logic [6:0] FSP_A4_BITS = 7'h20;
	localparam logic [6:0] FSP_B_BITS  = 7'h08;

	// Protection array geometry and reset values
	localparam int           FSP_NUM_SECT = 16;
	localparam int           FSP_SECT_LSB = 16;
	localparam logic [7:0]   FSP_VOL_RST  = 8'hff;
	localparam logic [7:0]   FSP_NV_RST   = 8'hff;
	localparam logic [7:0]   FSP_NV_PROG  = 8'h00;
	localparam logic [7:0]   FSP_NV_ERASE = 8'hff;
	localparam logic [15:0]  FSP_MODE_RST = 16'hffff;

	// Timing
	localparam int FSP_CLK_NS        = 10;
	localparam int FSP_PROG_TIME_NS  = 10000;
	localparam int FSP_ERASE_TIME_NS = 200000;
	localparam int FSP_PROG_CYC  = (FSP_PROG_TIME_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
	localparam int FSP_ERASE_CYC = (FSP_ERASE_TIME_NS + FSP_CLK_NS - 1) / FSP_CLK_NS;
	localparam int FSP_TIMER_W   = 24;
	localparam int FSP_SCK_HALF  = 8;

	// Controller registers (byte offsets) and fields
	localparam logic [7:0] FSP_REG_CTRL  = 8'h00;
	localparam logic [7:0] FSP_REG_ADDR  = 8'h04;
	localparam logic [7:0] FSP_REG_WDATA = 8'h08;
	localparam logic [7:0] FSP_REG_RDATA = 8'h0c;
	localparam int FSP_CTRL_OP_LSB = 0;
	localparam int FSP_CTRL_AB_LSB = 8;
	localparam int FSP_CTRL_WB_LSB = 12;
	localparam int FSP_CTRL_RB_LSB = 16;
	localparam int FSP_CTRL_DONE   = 30;
	localparam int FSP_CTRL_GO     = 31;

	typedef enum logic [2:0] {
		OP_NONE, OP_VOLW, OP_NVPG, OP_NVER, OP_MODEPG, OP_LOCKCLR
	} fsp_op_t;

	typedef enum logic {DS_IDLE, DS_BUSY} fsp_dev_st_t;

	typedef enum logic [2:0] {
		HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP
	} fsp_host_st_t;

endpackage

// *** verification/fsp_link_asserts.sv ***
// Checks on the protection link wires and the device status outputs
`timescale 1ns/100ps
module fsp_link_asserts #(
	parameter int PROG_CYC  = 400,
	parameter int ERASE_CYC = 800
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Link wires
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	// Device status
	input wire logic busy_flag,
	input wire logic write_enable_latch,
	input wire logic nv_protect_lock_bit
);
	logic [7:0]  hi_q;
	logic [15:0] bsy_q;

	////////////////////////////////////////////////////////////////////////////
	// Cycles since deselect, saturating so long idle spans stay cheap
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) hi_q <= 8'h00;
		else if (!cs_n) hi_q <= 8'h00;
		else if (hi_q != 8'hff) hi_q <= hi_q + 8'h01;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) bsy_q <= 16'h0000;
		else if (!busy_flag) bsy_q <= 16'h0000;
		else bsy_q <= bsy_q + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	AST_SCK_FRAMED: assert property ($rose(sck) |-> !cs_n)
		else $error("serial clock rose while deselected");
	AST_MISO_IDLE: assert property (hi_q > 8'h08 |-> !miso)
		else $error("data out not parked while deselected");
	AST_MISO_STEADY: assert property (sck && $past(sck) |-> $stable(miso))
		else $error("data out moved while serial clock high");
	AST_MOSI_STEADY: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("data in moved while serial clock high");
	// Synchroniser delay allows a few cycles between deselect and start
	AST_BUSY_AFTER_CS: assert property ($rose(busy_flag) |-> cs_n && hi_q <= 8'h08)
		else $error("busy rose away from a deselect edge");
	AST_BUSY_MIN: assert property ($fell(busy_flag) |-> int'(bsy_q) >= PROG_CYC - 1)
		else $error("busy ended early");
	AST_BUSY_MAX: assert property (busy_flag |-> int'(bsy_q) <= ERASE_CYC + 1)
		else $error("busy lasted too long");
	AST_WEL_CLR: assert property ($fell(write_enable_latch) |-> $fell(busy_flag))
		else $error("write enable latch cleared outside completion");
	AST_WEL_SET: assert property ($rose(write_enable_latch) |-> !busy_flag && cs_n)
		else $error("write enable latch set while busy");
	AST_LOCK_CLR: assert property ($changed(nv_protect_lock_bit) |-> !nv_protect_lock_bit && $fell(busy_flag))
		else $error("lock bit changed outside a clear");

	C_DONE: cover property ($fell(busy_flag));
	C_LOCK: cover property ($fell(nv_protect_lock_bit));
	C_POLL: cover property (busy_flag && !cs_n);
endmodule // fsp_link_asserts

// *** verification/tb_flash_sector_protection_cmds.sv ***
// Bench: controller and device ends joined, driven over Wishbone
`timescale 1ns/100ps
module tb_flash_sector_protection_cmds import fsp_pkg::*;;
	localparam int         PROG  = 1000;
	localparam int         ERASE = 2000;
	localparam logic [31:0] S2   = 32'h0002_0000;
	localparam logic [31:0] S3   = 32'h0003_0000;
	localparam logic [31:0] S4   = 32'h0004_0000;

	logic        sys_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]  wb_adr, bank_addr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	logic        quad_command_mode, busy_flag;
	logic        write_enable_latch, nv_protect_lock_bit;
	logic [15:0] r;
	int          fails, n_compared;

	fsp_link_if fsp_link_if_i ();
	fsp_dev #(.PROG_CYC(PROG), .ERASE_CYC(ERASE)) fsp_dev_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .link(fsp_link_if_i.dev),
		.bank_addr(bank_addr), .quad_command_mode(quad_command_mode),
		.busy_flag(busy_flag), .write_enable_latch(write_enable_latch),
		.nv_protect_lock_bit(nv_protect_lock_bit));
	fsp_host #(.SCK_HALF(4)) fsp_host_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .link(fsp_link_if_i.host));
	fsp_link_asserts #(.PROG_CYC(PROG), .ERASE_CYC(ERASE)) fsp_link_asserts_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(fsp_link_if_i.cs_n),
		.sck(fsp_link_if_i.sck), .mosi(fsp_link_if_i.mosi),
		.miso(fsp_link_if_i.miso), .busy_flag(busy_flag),
		.write_enable_latch(write_enable_latch),
		.nv_protect_lock_bit(nv_protect_lock_bit));

	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat_w <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 100);
		if (wb_ack !== 1'b1) begin
			fails++;
			$display("[FAIL] wb ack expected 1 seen %b", wb_ack);
		end
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	// One link frame; received bytes land in r
	task automatic fr(input logic [7:0] op, input int ab, wbn, rb,
		input logic [31:0] a, input logic [15:0] wd);
		int n;
		n = 0;
		wb(1'b1, FSP_REG_ADDR, a);
		wb(1'b1, FSP_REG_WDATA, {16'h0000, wd});
		wb(1'b1, FSP_REG_CTRL, {1'b1, 13'h0, 2'(rb), 2'h0, 2'(wbn), 1'b0,
			3'(ab), op});
		do begin
			wb(1'b0, FSP_REG_CTRL, 32'h0);
			n++;
		end while (q[FSP_CTRL_DONE] !== 1'b1 && n < 500);
		chk("frame done", 16'h0001, 16'(q[FSP_CTRL_DONE]));
		wb(1'b0, FSP_REG_RDATA, 32'h0);
		r = q[15:0];
	endtask

	task automatic stat();
		fr(FSP_OP_READ_STATUS, 0, 0, 1, 32'h0, 16'h0);
	endtask

	task automatic idle();
		for (int i = 0; i < 50; i++) begin
			stat();
			if (r[FSP_ST_BUSY] === 1'b0) break;
		end
		chk("idle", 16'h0000, 16'(r[FSP_ST_BUSY]));
	endtask

	task automatic wen();
		fr(FSP_OP_WRITE_ENABLE, 0, 0, 0, 32'h0, 16'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog well past the expected run length
	initial begin
		#900000;
		fails++;
		tally_and_finish();
	end

	initial begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		{wb_cyc, wb_stb, wb_we, quad_command_mode} = 4'h0;
		{wb_adr, bank_addr, wb_sel, wb_dat_w} = '0;
		fails = 0;
		n_compared = 0;
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 16'h0000, q[15:0]);
		fr(FSP_OP_RD_VOL, 3, 0, 2, S2, 16'h0);
		chk("vol reset", 16'hffff, r);
		fr(FSP_OP_RD_MODE, 0, 0, 2, 32'h0, 16'h0);
		chk("mode reset", 16'hffff, r);
		fr(FSP_OP_WR_VOL, 3, 1, 0, S2, 16'h005a);
		idle();
		fr(FSP_OP_RD_VOL, 3, 0, 2, S2, 16'h0);
		chk("vol no latch", 16'hffff, r);
		wen();
		fr(FSP_OP_WR_VOL, 3, 1, 0, S2, 16'h005a);
		idle();
		fr(FSP_OP_RD_VOL, 3, 0, 2, S2, 16'h0);
		chk("vol write", 16'h5a5a, r);
		chk("cs idle", 16'h0001, 16'(fsp_link_if_i.cs_n));
		bank_addr <= 8'h80;
		fr(FSP_OP_RD_VOL, 4, 0, 2, S2, 16'h0);
		chk("vol ext", 16'h5a5a, r);
		bank_addr <= 8'h00;
		fr(FSP_OP_RD_VOL_W, 4, 0, 2, S2, 16'h0);
		chk("vol wide", 16'h5a5a, r);
		wen();
		fr(FSP_OP_WR_VOL_W, 4, 1, 0, S4, 16'h00c3);
		idle();
		fr(FSP_OP_RD_VOL, 3, 0, 2, S4, 16'h0);
		chk("vol wide write", 16'hc3c3, r);
		wen();
		fr(FSP_OP_PG_NV, 3, 0, 0, S3, 16'h0);
		stat();
		chk("nv busy", 16'h0001, 16'(r[FSP_ST_BUSY]));
		fr(FSP_OP_RD_VOL, 3, 0, 2, S2, 16'h0);
		chk("read refused", 16'h0000, r);
		idle();
		chk("wel nv", 16'h0000, 16'(write_enable_latch));
		fr(FSP_OP_RD_NV, 3, 0, 2, S3, 16'h0);
		chk("nv prog", 16'h0000, r);
		fr(FSP_OP_RD_NV_W, 4, 0, 2, S4, 16'h0);
		chk("nv other", 16'hffff, r);
		quad_command_mode <= 1'b1;
		fr(FSP_OP_RD_NV, 3, 0, 2, S4, 16'h0);
		chk("nv quad", 16'h0000, r);
		fr(FSP_OP_RD_LOCK, 0, 0, 1, 32'h0, 16'h0);
		chk("lock quad", 16'h0000, r);
		quad_command_mode <= 1'b0;
		wen();
		fr(FSP_OP_ER_NV, 0, 1, 0, 32'h0, 16'h0);
		stat();
		chk("erase long", 16'h0000, 16'(r[FSP_ST_BUSY]));
		wen();
		fr(FSP_OP_ER_NV, 0, 0, 0, 32'h0, 16'h0);
		fr(FSP_OP_ERASE_SUSP, 0, 0, 0, 32'h0, 16'h0);
		stat();
		chk("no suspend", 16'h0001, 16'(r[FSP_ST_BUSY]));
		idle();
		fr(FSP_OP_RD_NV, 3, 0, 2, S3, 16'h0);
		chk("nv erase", 16'hffff, r);
		chk("wel erase", 16'h0000, 16'(write_enable_latch));
		wen();
		fr(FSP_OP_PG_NV_W, 4, 0, 0, S4, 16'h0);
		idle();
		fr(FSP_OP_RD_NV, 3, 0, 2, S4, 16'h0);
		chk("nv wide prog", 16'h0000, r);
		wen();
		fr(FSP_OP_PG_MODE, 0, 1, 0, 32'h0, 16'h1234);
		idle();
		fr(FSP_OP_RD_MODE, 0, 0, 2, 32'h0, 16'h0);
		chk("mode short", 16'hffff, r);
		wen();
		fr(FSP_OP_PG_MODE, 0, 2, 0, 32'h0, 16'h1234);
		idle();
		fr(FSP_OP_RD_MODE, 0, 0, 2, 32'h0, 16'h0);
		chk("mode prog", 16'h1234, r);
		chk("wel mode", 16'h0000, 16'(write_enable_latch));
		wen();
		fr(FSP_OP_CLR_LOCK, 0, 1, 0, 32'h0, 16'h0);
		idle();
		chk("lock long", 16'h0001, 16'(nv_protect_lock_bit));
		fr(FSP_OP_RD_LOCK, 0, 0, 2, 32'h0, 16'h0);
		chk("lock read", 16'h0101, r);
		wen();
		fr(FSP_OP_CLR_LOCK, 0, 0, 0, 32'h0, 16'h0);
		idle();
		chk("lock clear", 16'h0000, 16'(nv_protect_lock_bit));
		chk("wel lock", 16'h0000, 16'(write_enable_latch));
		tally_and_finish();
	end
endmodule // tb_flash_sector_protection_cmds
